/* core/bfp_pkg.sv */
// Shared constants, types and register map for the buck fault protection sequencer.
package bfp_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CH_N   = 2;

  localparam int unsigned OC_TRIP = 32;
  localparam int unsigned UV_TRIP = 8;
  localparam int unsigned OV_TRIP = 32;
  localparam int unsigned RUN_W   = 6;

  localparam int unsigned POS_W   = 8;
  localparam int unsigned EVT_W   = 16;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_DUTY0  = 8'h08;
  localparam logic [7:0] ADDR_DUTY1  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EVENTS = 8'h14;
  localparam logic [7:0] ADDR_FLAGS  = 8'h18;

  localparam logic [1:0]       CTRL_RST   = 2'h3;
  localparam logic [POS_W-1:0] PERIOD_RST = 8'h63;
  localparam logic [POS_W-1:0] PERIOD_MIN = 8'h03;
  localparam logic [POS_W-1:0] DUTY_RST   = 8'h00;

  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_OCT_BIT   = 5;
  localparam int unsigned STAT_OV_BIT    = 6;
  localparam int unsigned STAT_UV_BIT    = 7;
  localparam int unsigned STAT_STRIDE    = 8;
  localparam int unsigned FLAG_STRIDE    = 2;
  localparam int unsigned FLAG_HIC_BIT   = 0;
  localparam int unsigned FLAG_OVL_BIT   = 1;

  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_SOFT   = 5'h02,
    ST_RUN    = 5'h04,
    ST_HICCUP = 5'h08,
    ST_OVLAT  = 5'h10
  } bfp_state_t;

  // Comparator and pin levels of one channel, all from outside the clock domain.
  typedef struct packed {
    logic oc;       // Switch node below the overcurrent setpoint pin.
    logic uv;       // Feedback input at or below 82% of reference.
    logic ov;       // Feedback input at or above 116% of reference.
    logic ss_en;    // Soft-start pin above 1V.
    logic ss_3v;    // Soft-start ramp at about 3V.
    logic ss_done;  // Soft-start ramp past about 3.2V.
    logic zc;       // Inductor current crossed zero.
  } bfp_cmp_t;

  typedef struct packed {
    logic ugate;
    logic ugate_oe_n;
    logic lgate;
    logic lgate_oe_n;
    logic ss_pull;
  } bfp_gate_t;

endpackage

/* core/bfp_run_counter.sv */
// Consecutive-cycle fault run counter with a trip level.
module bfp_run_counter
  import bfp_pkg::*;
#(
  parameter int unsigned TRIP = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic fault,
  input  wire logic hold,
  output logic      trip
);

  localparam logic [RUN_W-1:0] TRIP_CNT = RUN_W'(TRIP);
  localparam logic [RUN_W-1:0] ONE      = RUN_W'(1);

  logic [RUN_W-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (hold) begin
      count <= '0;
    end else if (tick) begin
      if (!fault) begin
        count <= '0;
      end else if (count != TRIP_CNT) begin
        count <= count + ONE;
      end
    end
  end

  assign trip = (count == TRIP_CNT);

endmodule

/* core/bfp_top.sv */
// Two-channel buck fault protection sequencer with an APB register port.
//
// Added by the designer: the placing of the registers and register access over APB.
module bfp_top
  import bfp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire bfp_cmp_t [CH_N-1:0] cmp_pin,
  output bfp_gate_t     [CH_N-1:0] gate_out
);

  // Pin synchroniser; only the second stage is read by logic.
  bfp_cmp_t [CH_N-1:0] cmp_meta;
  bfp_cmp_t [CH_N-1:0] cmp_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_meta <= '0;
      cmp_sync <= '0;
    end else begin
      cmp_meta <= cmp_pin;
      cmp_sync <= cmp_meta;
    end
  end

  // Registers written by software.
  logic [1:0]       ctrl_en;
  logic [POS_W-1:0] period;
  logic [POS_W-1:0] duty [CH_N];
  logic [CH_N*FLAG_STRIDE-1:0] flags;

  // Per-channel state.
  bfp_state_t       state      [CH_N];
  bfp_state_t       next_state [CH_N];
  logic [POS_W-1:0] pos        [CH_N];
  logic [EVT_W-1:0] oc_events  [CH_N];
  logic [CH_N-1:0]  tick;
  logic [CH_N-1:0]  oc_term;
  logic [CH_N-1:0]  oc_hit;
  logic [CH_N-1:0]  oc_trip;
  logic [CH_N-1:0]  uv_trip;
  logic [CH_N-1:0]  ov_trip;
  logic [CH_N-1:0]  hic_enter;
  logic [CH_N-1:0]  ovl_enter;
  bfp_gate_t [CH_N-1:0] next_gate;

  // Switching oscillator. Channel 1 ticks half a period after channel 0.
  logic [POS_W-1:0] osc_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= '0;
    end else if (osc_cnt >= period) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + POS_W'(1);
    end
  end

  assign tick[0] = (osc_cnt == period);
  assign tick[1] = (osc_cnt == (period >> 1));

  genvar c;
  generate
    for (c = 0; c < CH_N; c++) begin : g_ch

      // Position inside this channel's switching cycle.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pos[c] <= '0;
        end else if (tick[c]) begin
          pos[c] <= '0;
        end else if (pos[c] != '1) begin
          pos[c] <= pos[c] + POS_W'(1);
        end
      end

      // The comparison is only meaningful while the upper switch conducts.
      // The synchronised comparator lags the gate by two clocks, so an upper pulse
      // shorter than three clocks is never seen; a longer pulse is cut on the third.
      assign oc_hit[c] = gate_out[c].ugate && cmp_sync[c].oc;

      // The termination holds for the rest of the cycle; the cycle edge clears it.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          oc_term[c] <= 1'b0;
        end else if (tick[c]) begin
          oc_term[c] <= 1'b0;
        end else if (oc_hit[c]) begin
          oc_term[c] <= 1'b1;
        end
      end

      // Total overcurrent detections, counted once per terminated pulse.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          oc_events[c] <= '0;
        end else if (oc_hit[c] && !oc_term[c] && oc_events[c] != '1) begin
          oc_events[c] <= oc_events[c] + EVT_W'(1);
        end
      end

      bfp_run_counter #(
        .TRIP (OC_TRIP)
      ) u_oc_run (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick[c]),
        .fault (oc_term[c] || oc_hit[c]),
        .hold  (state[c] != ST_RUN),
        .trip  (oc_trip[c])
      );

      bfp_run_counter #(
        .TRIP (UV_TRIP)
      ) u_uv_run (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick[c]),
        .fault (cmp_sync[c].uv),
        .hold  (state[c] != ST_RUN && state[c] != ST_OVLAT),
        .trip  (uv_trip[c])
      );

      // Counting only in RUN means the soft-start done signal is already true.
      bfp_run_counter #(
        .TRIP (OV_TRIP)
      ) u_ov_run (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick[c]),
        .fault (cmp_sync[c].ov),
        .hold  (state[c] != ST_RUN),
        .trip  (ov_trip[c])
      );

      always_comb begin
        next_state[c] = state[c];
        if (!cmp_sync[c].ss_en || !ctrl_en[c]) begin
          // A low soft-start pin ends every state, the latch included.
          next_state[c] = ST_OFF;
        end else begin
          unique case (state[c])
            ST_OFF: begin
              next_state[c] = ST_SOFT;
            end
            ST_SOFT: begin
              if (cmp_sync[c].ss_done) begin
                next_state[c] = ST_RUN;
              end else if (tick[c] && cmp_sync[c].ss_3v && (oc_term[c] || oc_hit[c])) begin
                next_state[c] = ST_HICCUP;
              end
            end
            ST_RUN: begin
              if (oc_trip[c]) begin
                next_state[c] = ST_HICCUP;
              end else if (uv_trip[c]) begin
                next_state[c] = ST_HICCUP;
              end else if (ov_trip[c]) begin
                next_state[c] = ST_OVLAT;
              end
            end
            ST_HICCUP: begin
              // Discharge continues until the pin falls below 1V.
              next_state[c] = ST_HICCUP;
            end
            ST_OVLAT: begin
              if (uv_trip[c]) begin
                next_state[c] = ST_HICCUP;
              end
            end
          endcase
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          state[c] <= ST_OFF;
        end else begin
          state[c] <= next_state[c];
        end
      end

      assign hic_enter[c] = (next_state[c] == ST_HICCUP) && (state[c] != ST_HICCUP);
      assign ovl_enter[c] = (next_state[c] == ST_OVLAT) && (state[c] != ST_OVLAT);

      // Gate drive. Duty 0 never turns the upper gate on; duty all-ones always does, except one clock per cycle at period 8'hFF.
      always_comb begin
        next_gate[c] = '0;
        unique case (next_state[c])
          ST_OFF: begin
            next_gate[c] = '0;
          end
          ST_SOFT: begin
            // Lower gate held off so a pre-charged output is not pulled down.
            next_gate[c].ugate = (pos[c] < duty[c]) && !oc_term[c] && !oc_hit[c];
            next_gate[c].lgate = 1'b0;
          end
          ST_RUN: begin
            if (cmp_sync[c].ov) begin
              next_gate[c].ugate = 1'b0;
              next_gate[c].lgate = !cmp_sync[c].zc;
            end else begin
              next_gate[c].ugate = (pos[c] < duty[c]) && !oc_term[c] && !oc_hit[c];
              next_gate[c].lgate = !((pos[c] < duty[c]) && !oc_term[c] && !oc_hit[c]);
            end
          end
          ST_HICCUP: begin
            next_gate[c].ss_pull = 1'b1;
          end
          ST_OVLAT: begin
            next_gate[c].ugate_oe_n = 1'b1;
            next_gate[c].lgate_oe_n = 1'b1;
            next_gate[c].ss_pull    = 1'b0;
          end
        endcase
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          gate_out[c] <= '0;
        end else begin
          gate_out[c] <= next_gate[c];
        end
      end

    end
  endgenerate

  // APB slave: zero wait states, read data captured in the setup cycle.
  logic wr_en;
  logic rd_setup;
  logic addr_hit;

  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    unique case (paddr)
      ADDR_CTRL, ADDR_PERIOD, ADDR_DUTY0, ADDR_DUTY1,
      ADDR_STATUS, ADDR_EVENTS, ADDR_FLAGS: addr_hit = 1'b1;
      default:                              addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en <= CTRL_RST;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      ctrl_en <= pwdata[1:0];
    end
  end

  // A period below the floor would leave no room for the half-period offset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period <= PERIOD_RST;
    end else if (wr_en && paddr == ADDR_PERIOD) begin
      period <= (pwdata[POS_W-1:0] < PERIOD_MIN) ? PERIOD_MIN : pwdata[POS_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty[0] <= DUTY_RST;
      duty[1] <= DUTY_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_DUTY0) begin
        duty[0] <= pwdata[POS_W-1:0];
      end
      if (paddr == ADDR_DUTY1) begin
        duty[1] <= pwdata[POS_W-1:0];
      end
    end
  end

  // Sticky entry flags, write one to clear; a new entry wins over the clear.
  logic [CH_N*FLAG_STRIDE-1:0] flag_set;
  logic [CH_N*FLAG_STRIDE-1:0] flag_clr;

  always_comb begin
    flag_set = '0;
    for (int i = 0; i < CH_N; i++) begin
      flag_set[i*FLAG_STRIDE+FLAG_HIC_BIT] = hic_enter[i];
      flag_set[i*FLAG_STRIDE+FLAG_OVL_BIT] = ovl_enter[i];
    end
  end

  assign flag_clr = (wr_en && paddr == ADDR_FLAGS) ? pwdata[CH_N*FLAG_STRIDE-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  logic [31:0] status_word;
  logic [31:0] rd_word;

  // Each channel reports in a byte of its own, so one read shows both channels.
  always_comb begin
    status_word = '0;
    for (int i = 0; i < CH_N; i++) begin
      status_word[i*STAT_STRIDE+STAT_STATE_LSB +: $bits(bfp_state_t)] = state[i];
      status_word[i*STAT_STRIDE+STAT_OCT_BIT]        = oc_term[i];
      status_word[i*STAT_STRIDE+STAT_OV_BIT]         = cmp_sync[i].ov;
      status_word[i*STAT_STRIDE+STAT_UV_BIT]         = cmp_sync[i].uv;
    end
  end

  always_comb begin
    unique case (paddr)
      ADDR_CTRL:   rd_word = {30'h0000_0000, ctrl_en};
      ADDR_PERIOD: rd_word = {24'h00_0000, period};
      ADDR_DUTY0:  rd_word = {24'h00_0000, duty[0]};
      ADDR_DUTY1:  rd_word = {24'h00_0000, duty[1]};
      ADDR_STATUS: rd_word = status_word;
      ADDR_EVENTS: rd_word = {oc_events[1], oc_events[0]};
      ADDR_FLAGS:  rd_word = {28'h000_0000, flags};
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end

endmodule

/* test/bfp_chk.sv */
// Port assertions for the buck fault protection sequencer.
module bfp_chk
  import bfp_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [7:0]           paddr,
  input wire logic                 pslverr,
  input wire bfp_cmp_t [CH_N-1:0]  cmp_pin,
  input wire bfp_gate_t [CH_N-1:0] gate_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  bfp_cmp_t   c0;
  bfp_gate_t  g0;
  logic [5:0] gap [CH_N];
  assign c0 = cmp_pin[0];
  assign g0 = gate_out[0];
  // Cycles since the last fault level; a hiccup long after any fault is spurious.
  always_ff @(posedge clk or negedge rst_n) begin
    for (int c = 0; c < CH_N; c++) begin
      if (!rst_n) begin
        gap[c] <= 6'h3F;
      end else if (cmp_pin[c].oc || cmp_pin[c].uv) begin
        gap[c] <= 6'h00;
      end else if (gap[c] != 6'h3F) begin
        gap[c] <= gap[c] + 6'h01;
      end
    end
  end
  a_oc_ends_pulse: assert property ($rose(c0.oc) |-> ##[1:4] !g0.ugate)
    else $error("upper pulse not ended");
  a_soft_lgate_off: assert property (!g0.ugate_oe_n && !$past(c0.ss_done, 3)
    && !$past(c0.ss_done, 4) |-> !g0.lgate) else $error("lower gate on in soft-start");
  a_ov_upper_off: assert property ($past(c0.ov, 4) && $past(c0.ov, 5)
    && $past(c0.ss_done, 6) && !g0.ss_pull |-> !g0.ugate) else $error("upper on in ov");
  a_latch_floats: assert property (g0.ugate_oe_n |-> g0.lgate_oe_n && !g0.ss_pull)
    else $error("latch not floating");
  a_latch_cause: assert property ($rose(g0.ugate_oe_n)
    |-> $past(c0.ov, 4) && $past(c0.ss_done, 4)) else $error("latch without ov");
  a_pull_holds: assert property (g0.ss_pull && c0.ss_en && $past(c0.ss_en)
    && $past(c0.ss_en, 2) |=> g0.ss_pull) else $error("pull dropped early");
  a_pull_release: assert property ($fell(c0.ss_en) |-> ##[1:5] !g0.ss_pull)
    else $error("pull not released");
  a_latch_release: assert property ($fell(c0.ss_en) && g0.ugate_oe_n
    |-> ##[1:5] !g0.ugate_oe_n) else $error("latch not released");
  a_trip_cause0: assert property ($rose(g0.ss_pull) |-> gap[0] < 6'h08)
    else $error("ch0 hiccup without fault");
  a_trip_cause1: assert property ($rose(gate_out[1].ss_pull) |-> gap[1] < 6'h08)
    else $error("ch1 hiccup without fault");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("no error on unmapped");
  c_hiccup: cover property ($rose(g0.ss_pull));
  c_latch: cover property ($rose(g0.ugate_oe_n));
  c_oc: cover property ($rose(c0.oc));
endmodule

bind bfp_top bfp_chk chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .cmp_pin(cmp_pin), .gate_out(gate_out));

/* test/bfp_far.sv */
// Far-side model of one channel: switch node, feedback divider and soft-start pin.
module bfp_far
  import bfp_pkg::*;
(
  input  wire logic      clk,
  input  wire bfp_gate_t gate,
  input  wire logic      sh,
  input  wire logic      uvl,
  input  wire logic      ovl,
  input  wire logic      zci,
  input  wire logic      hold,
  output bfp_cmp_t       cmp
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin level in 25mV steps (40 per volt); discharge is fast so a hiccup stays short.
  int v = 0;
  always @(posedge clk) begin
    if (gate.ss_pull || hold) begin
      v <= (v > 4) ? v - 4 : 0;
    end else if (v < 160) begin
      v <= v + 1;
    end
  end
  always_comb begin
    cmp.oc      = gate.ugate && sh;
    cmp.uv      = uvl;
    cmp.ov      = ovl;
    cmp.ss_en   = v >= 40;
    cmp.ss_3v   = v >= 120;
    cmp.ss_done = v >= 128;
    cmp.zc      = zci;
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the two-channel fault sequencer.
module tb_top
  import bfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                 pwrite = 1'b0, pready, pslverr, err;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata, r;
  logic [1:0]           sh = 2'h0, uvl = 2'h0, ovl = 2'h0, zci = 2'h0, hold = 2'h0;
  bfp_cmp_t [CH_N-1:0]  cmp_pin;
  bfp_gate_t [CH_N-1:0] gate_out;
  bfp_state_t           m_st [CH_N] = '{ST_RUN, ST_RUN};
  int                   fail_count = 0, check_count = 0;
  logic [7:0]           ra [5] = '{ADDR_CTRL, ADDR_PERIOD, ADDR_DUTY0, ADDR_DUTY1, ADDR_FLAGS};
  logic [31:0]          rv [5] = '{{30'h0, CTRL_RST}, {24'h0, PERIOD_RST},
                                   {24'h0, DUTY_RST}, {24'h0, DUTY_RST}, 32'h0};
  always #20 clk = ~clk;
  bfp_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_pin(cmp_pin), .gate_out(gate_out));
  for (genvar c = 0; c < CH_N; c++) begin : g_far
    bfp_far far_u (.clk(clk), .gate(gate_out[c]), .sh(sh[c]), .uvl(uvl[c]), .ovl(ovl[c]),
      .zci(zci[c]), .hold(hold[c]), .cmp(cmp_pin[c]));
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // The model keeps the expected state of both channels; only the last poll checks both.
  task automatic wait_st(input int c, input bfp_state_t s);
    int n;
    m_st[c] = s;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (r[c*8 +: 5] !== s && n < 400);
    chk(32'(r[c*8 +: 5]), 32'(s), "state");
    chk(32'(r[(1-c)*8 +: 5]), 32'(m_st[1-c]), "other channel state");
  endtask
  task automatic duty(input logic [7:0] d, input logic v);
    apb(1'b1, ADDR_DUTY0, {24'h0, d});
    repeat (8) @(posedge clk);
    repeat (8) begin
      @(negedge clk);
      chk(32'(gate_out[0].ugate), 32'(v), "duty");
    end
  endtask
  initial begin
    void'($urandom(32'hEC722411));
    forever begin
      @(posedge clk);
      for (int c = 0; c < CH_N; c++) zci[c] <= ovl[c] ? 1'b0 : 1'($urandom);
    end
  end
  initial begin
    #2000000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(r, rv[i], "reset value");
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({r[30:0], err}, 32'h1, "unmapped read");
    apb(1'b1, ADDR_PERIOD, 32'h1);
    apb(1'b0, ADDR_PERIOD, 32'h0);
    chk(r, {24'h0, PERIOD_MIN}, "period clamp");
    // Three clocks of upper on-time outlast the comparator synchroniser.
    apb(1'b1, ADDR_DUTY0, 32'h3);
    apb(1'b1, ADDR_DUTY1, 32'h3);
    wait_st(0, ST_RUN);
    wait_st(1, ST_RUN);
    duty(8'h00, 1'b0);
    duty(8'hFF, 1'b1);
    apb(1'b1, ADDR_DUTY0, 32'h3);
    sh[0] <= 1'b1;
    wait_st(0, ST_HICCUP);
    apb(1'b0, ADDR_EVENTS, 32'h0);
    chk({r[31:16], 15'h0, r[15:0] >= 16'h0020}, 32'h1, "events");
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk(r, 32'h1, "hiccup flag");
    apb(1'b1, ADDR_FLAGS, 32'h1);
    wait_st(0, ST_SOFT);
    wait_st(0, ST_HICCUP);
    sh[0] <= 1'b0;
    wait_st(0, ST_RUN);
    // Seven-tick undervoltage runs broken by clean ticks must never trip.
    repeat (3) begin
      uvl[0] <= 1'b1;
      repeat (28) @(posedge clk);
      uvl[0] <= 1'b0;
      repeat (8) @(posedge clk);
    end
    wait_st(0, ST_RUN);
    uvl[0] <= 1'b1;
    wait_st(0, ST_HICCUP);
    uvl[0] <= 1'b0;
    wait_st(0, ST_RUN);
    ovl[0] <= 1'b1;
    repeat (12) @(negedge clk);
    chk(32'({gate_out[0].ugate, gate_out[0].lgate}), 32'h1, "ov gates");
    wait_st(0, ST_OVLAT);
    chk(32'(r[STAT_OV_BIT]), 32'h1, "ov status");
    chk(32'({gate_out[0].ugate_oe_n, gate_out[0].lgate_oe_n, gate_out[0].ss_pull}),
        32'h6, "latch gates");
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk(r & 32'h2, 32'h2, "latch flag");
    ovl[0] <= 1'b0;
    uvl[0] <= 1'b1;
    wait_st(0, ST_HICCUP);
    uvl[0] <= 1'b0;
    wait_st(0, ST_RUN);
    ovl[0] <= 1'b1;
    wait_st(0, ST_OVLAT);
    ovl[0] <= 1'b0;
    hold[0] <= 1'b1;
    wait_st(0, ST_OFF);
    hold[0] <= 1'b0;
    wait_st(0, ST_RUN);
    apb(1'b1, ADDR_CTRL, 32'h2);
    wait_st(0, ST_OFF);
    apb(1'b1, ADDR_CTRL, {30'h0, CTRL_RST});
    wait_st(0, ST_RUN);
    sh[1] <= 1'b1;
    wait_st(1, ST_HICCUP);
    sh[1] <= 1'b0;
    wait_st(1, ST_RUN);
    final_report;
  end
endmodule
